//--- asc_sequencer.sv
// Purpose: Control sequencer of a 10-bit successive approximation converter
// Assumes: standby_in comes from clock-domain logic and is high in STOP or SLOW
// Notes: Registers on a plain port, read data one cycle after the read strobe
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module asc_sequencer (
	input  wire logic                clk_sys_in,
	input  wire logic                arst_n_in,
	input  wire asc_pkg::asc_bus_t   bus_in,
	input  wire logic                standby_in,
	input  wire logic                cmp_in,
	output logic [7:0]               rdata_out,
	output asc_pkg::asc_analog_t     analog_out,
	output logic                     conversion_done_irq_out
);
	typedef struct packed {
		asc_pkg::asc_state_t         st;
		logic                        start;
		logic [1:0]                  mode;
		logic                        ain_off;
		logic [3:0]                  chan;
		logic [asc_pkg::CTRL2_W-1:0] ctrl2;
		logic [asc_pkg::RES_W-1:0]   result;
		logic                        eoc;
		logic                        irq;
		logic [7:0]                  rdata;
	} asc_regs_t;

	asc_regs_t                 r;
	asc_regs_t                 n;
	logic                      busy;
	logic                      t_start;
	logic                      t_abort;
	logic                      t_decide;
	logic                      t_sample;
	logic                      t_last;
	logic                      wr_one;
	logic                      off_write;
	logic                      rd_upper;
	logic [asc_pkg::RES_W-1:0] sar_dac;
	logic [asc_pkg::RES_W-1:0] sar_final;
	logic [1:0]                wr_mode;

	function automatic logic [7:0] read_mux(input asc_regs_t q, input logic bsy,
		input logic [asc_pkg::ADDR_W-1:0] a);
		case (a)
			asc_pkg::ADDR_CTRL_ONE:  read_mux = {q.start, q.mode, q.ain_off, q.chan};
			asc_pkg::ADDR_CTRL_TWO:  read_mux = {2'h0, q.ctrl2};
			asc_pkg::ADDR_RES_UPPER: read_mux = q.result[asc_pkg::RES_W-1:2];
			asc_pkg::ADDR_RES_STAT:  read_mux = {q.result[1:0], q.eoc, bsy, 4'h0};
			default:                 read_mux = 8'h00;
		endcase
	endfunction: read_mux

	function automatic logic mode_runs(input logic [1:0] m);
		mode_runs = (m == asc_pkg::MODE_SW) || (m == asc_pkg::MODE_RPT);
	endfunction: mode_runs

	assign busy      = (r.st == asc_pkg::ASC_CONV);
	assign wr_one    = bus_in.wr && (bus_in.addr == asc_pkg::ADDR_CTRL_ONE);
	assign wr_mode   = bus_in.wdata[asc_pkg::MODE_LSB +: 2];
	assign off_write = wr_one && (wr_mode == asc_pkg::MODE_OFF);
	assign rd_upper  = bus_in.rd && (bus_in.addr == asc_pkg::ADDR_RES_UPPER);

	asc_conv_timer u_timer (
		.clk_sys_in (clk_sys_in),
		.arst_n_in  (arst_n_in),
		.start_in   (t_start),
		.abort_in   (t_abort),
		.code_in    (r.ctrl2[asc_pkg::TIME_LSB +: 3]),
		.decide_out (t_decide),
		.sample_out (t_sample),
		.last_out   (t_last)
	);

	asc_sar u_sar (
		.clk_sys_in (clk_sys_in),
		.arst_n_in  (arst_n_in),
		.load_in    (t_start),
		.decide_in  (t_decide),
		.cmp_in     (cmp_in),
		.dac_out    (sar_dac),
		.final_out  (sar_final)
	);

	always_comb
	begin
		n       = r;
		n.irq   = 1'b0;
		n.rdata = 8'h00;
		t_start = 1'b0;
		t_abort = 1'b0;
		if (standby_in)
		begin
			// Standby wipes configuration and results and ignores writes
			n       = '0;
			t_abort = busy;
		end
		else
		begin
			if (wr_one)
			begin
				n.chan    = bus_in.wdata[asc_pkg::CHAN_LSB +: 4];
				n.ain_off = bus_in.wdata[asc_pkg::AIN_OFF_BIT];
				n.mode    = wr_mode;
				n.start   = bus_in.wdata[asc_pkg::START_BIT] && !busy;
			end
			if (bus_in.wr && (bus_in.addr == asc_pkg::ADDR_CTRL_TWO))
				n.ctrl2 = bus_in.wdata[asc_pkg::CTRL2_W-1:0];
			if (bus_in.rd)
			begin
				n.rdata = read_mux(r, busy, bus_in.addr);
				if (rd_upper)
					n.eoc = 1'b0;
			end
			case (r.st)
				asc_pkg::ASC_IDLE:
				begin
					if (r.start)
					begin
						n.start = 1'b0;
						if (mode_runs(r.mode))
						begin
							t_start = 1'b1;
							n.st    = asc_pkg::ASC_CONV;
							n.eoc   = 1'b0;
						end
					end
				end
				asc_pkg::ASC_CONV:
				begin
					n.start = 1'b0;
					if (off_write)
					begin
						// Abort wins over a completion in the same cycle
						t_abort = 1'b1;
						n.st    = asc_pkg::ASC_IDLE;
					end
					else if (t_last)
					begin
						n.result = sar_final;
						n.eoc    = 1'b1;
						n.irq    = 1'b1;
						if (r.mode == asc_pkg::MODE_RPT)
							t_start = 1'b1;
						else
							n.st = asc_pkg::ASC_IDLE;
					end
				end
				default:
				begin
					n.st = asc_pkg::ASC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			r <= '0;
		else
			r <= n;
	end

	assign rdata_out               = r.rdata;
	assign conversion_done_irq_out = r.irq;
	assign analog_out.chan         = r.chan;
	assign analog_out.input_off    = r.ain_off;
	assign analog_out.sample       = t_sample;
	assign analog_out.dac          = sar_dac;
	// Ladder is on while its control bit is set or a conversion runs; standby always cuts it
	assign analog_out.ladder_on    = !standby_in && (r.ctrl2[asc_pkg::LADDER_BIT] || busy);

	sequence s_sw_armed;
		!standby_in && !busy && r.start && (r.mode == asc_pkg::MODE_SW);
	endsequence

	sequence s_done;
		!standby_in && busy && t_last && !off_write;
	endsequence

	a_sw_start_go: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		s_sw_armed |=> busy && !r.eoc)
		else $error("software start did not begin a conversion");

	a_start_clears: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		$rose(busy) |-> !r.start ##1 !r.start)
		else $error("start bit still set after conversion began");

	a_done_flags: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		s_done |=> r.eoc && r.irq && (r.result == $past(sar_final)))
		else $error("completion did not store result with flag and interrupt");

	a_repeat_next: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		s_done ##0 (r.mode == asc_pkg::MODE_RPT) |=> busy)
		else $error("repeat mode did not continue");

	a_rpt_start_go: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(!standby_in && !busy && r.start && (r.mode == asc_pkg::MODE_RPT)) |=> busy)
		else $error("repeat start did not begin");

	a_abort_no_store: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(!standby_in && busy && off_write) |=> !busy && $stable(r.result) && !r.irq)
		else $error("disable did not abort cleanly");

	a_read_clr_flag: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(!standby_in && rd_upper && !(busy && t_last && !off_write)) |=> !r.eoc)
		else $error("reading the upper result left the flag set");

	a_standby_init: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		standby_in |=> (r.mode == asc_pkg::MODE_OFF) && (r.ctrl2 == '0) && !busy && !r.start)
		else $error("standby did not reinitialise the converter");

	a_no_resume: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		$fell(standby_in) |-> !busy ##1 !busy)
		else $error("conversion resumed after standby");

	a_ladder_cut: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		standby_in ##1 standby_in |-> !analog_out.ladder_on && !busy)
		else $error("ladder connected during standby");

	a_ladder_idle: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(!busy && !r.ctrl2[asc_pkg::LADDER_BIT]) |-> !analog_out.ladder_on)
		else $error("ladder connected while idle in conversion-only setting");

	a_busy_span: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		$fell(busy) |-> $past(standby_in) || $past(off_write) || $past(t_last))
		else $error("busy fell without cause");

	a_irq_pulse: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		r.irq |=> !r.irq)
		else $error("completion interrupt longer than one cycle");
endmodule: asc_sequencer

//--- asc_pkg.sv
// Purpose: Shared constants and types of the converter sequencer
// Assumes: One conversion-time unit is one system clock period
// Notes: Register addresses are word indices on the plain register port
package asc_pkg;
	localparam int unsigned ADDR_W = 2;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE  = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO  = 2'h1;
	localparam logic [ADDR_W-1:0] ADDR_RES_UPPER = 2'h2;
	localparam logic [ADDR_W-1:0] ADDR_RES_STAT  = 2'h3;
	localparam int unsigned RES_W = 10;
	localparam int unsigned START_BIT  = 7;
	localparam int unsigned MODE_LSB   = 5;
	localparam int unsigned AIN_OFF_BIT = 4;
	localparam int unsigned CHAN_LSB   = 0;
	localparam int unsigned CTRL2_W    = 6;
	localparam int unsigned LADDER_BIT = 5;
	localparam int unsigned TIME_LSB   = 1;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SW  = 2'h1;
	localparam logic [1:0] MODE_RPT = 2'h3;
	localparam logic [2:0] TIME_39   = 3'h0;
	localparam logic [2:0] TIME_78   = 3'h2;
	localparam logic [2:0] TIME_156  = 3'h3;
	localparam logic [2:0] TIME_312  = 3'h4;
	localparam logic [2:0] TIME_624  = 3'h5;
	// Shortest conversion in system clock periods, and cycles per period
	localparam int unsigned CONV_TIME_MIN_FC = 39;
	localparam int unsigned CYC_PER_FC       = 1;
	localparam int unsigned SLOTS            = 13;
	localparam int unsigned SAMPLE_SLOTS     = 3;
	localparam logic [6:0]  BASE_SLOT = 7'(CONV_TIME_MIN_FC * CYC_PER_FC / SLOTS);
	localparam logic [RES_W-1:0] SAR_FIRST = 10'h200;
	typedef enum logic [0:0] {ASC_IDLE = 1'b0, ASC_CONV = 1'b1} asc_state_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} asc_bus_t;
	typedef struct packed {
		logic [3:0]       chan;
		logic             input_off;
		logic             ladder_on;
		logic             sample;
		logic [RES_W-1:0] dac;
	} asc_analog_t;
	// Slot length is the base slot shifted left by this amount
	function automatic logic [2:0] slot_shift(input logic [2:0] code);
		case (code)
			TIME_39:  slot_shift = 3'h0;
			TIME_78:  slot_shift = 3'h1;
			TIME_156: slot_shift = 3'h2;
			TIME_312: slot_shift = 3'h3;
			TIME_624: slot_shift = 3'h4;
			default:  slot_shift = 3'h5;
		endcase
	endfunction: slot_shift
endpackage: asc_pkg

//--- asc_conv_timer.sv
// Purpose: Times one conversion as thirteen equal slots
// Assumes: start_in and abort_in are one-cycle pulses
// Notes: Three sampling slots, then ten decision slots
`timescale 1ns/1ps
module asc_conv_timer (
	input  wire logic       clk_sys_in,
	input  wire logic       arst_n_in,
	input  wire logic       start_in,
	input  wire logic       abort_in,
	input  wire logic [2:0] code_in,
	output logic            decide_out,
	output logic            sample_out,
	output logic            last_out
);
	typedef struct packed {
		logic       run;
		logic [2:0] shift;
		logic [6:0] cnt;
		logic [3:0] slot;
	} asc_timer_t;
	asc_timer_t r, n;
	logic [6:0] slot_len;
	logic       slot_end;
	logic [10:0] el;

	assign slot_len   = asc_pkg::BASE_SLOT << r.shift;
	assign slot_end   = r.run && (r.cnt == 7'h00);
	assign last_out   = slot_end && (r.slot == 4'(asc_pkg::SLOTS - 1));
	assign decide_out = slot_end && (r.slot >= 4'(asc_pkg::SAMPLE_SLOTS));
	assign sample_out = r.run && (r.slot < 4'(asc_pkg::SAMPLE_SLOTS));

	always_comb
	begin
		n = r;
		if (r.run)
			n.cnt = r.cnt - 7'h01;
		if (slot_end)
		begin
			n.cnt  = slot_len - 7'h01;
			n.slot = r.slot + 4'h1;
			if (last_out)
				n.run = 1'b0;
		end
		if (start_in)
		begin
			n.run   = 1'b1;
			n.shift = asc_pkg::slot_shift(code_in);
			n.cnt   = (asc_pkg::BASE_SLOT << n.shift) - 7'h01;
			n.slot  = 4'h0;
		end
		if (abort_in)
			n.run = 1'b0;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			r <= '0;
		else
			r <= n;
	end

	// Run cycles since the last start, for checking only
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			el <= 11'h000;
		else if (start_in)
			el <= 11'h001;
		else if (r.run)
			el <= el + 11'h001;
	end

	a_conv_exact_len: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		last_out |-> el == 11'(asc_pkg::SLOTS) * (11'(asc_pkg::BASE_SLOT) << r.shift))
		else $error("conversion length differs from selected time");
endmodule: asc_conv_timer

//--- asc_sar.sv
// Purpose: Successive approximation register with comparator input
// Assumes: Comparator output is asynchronous to the system clock
// Notes: A decision uses the filtered comparator level
`timescale 1ns/1ps
module asc_sar (
	input  wire logic                         clk_sys_in,
	input  wire logic                         arst_n_in,
	input  wire logic                         load_in,
	input  wire logic                         decide_in,
	input  wire logic                         cmp_in,
	output logic [asc_pkg::RES_W-1:0]         dac_out,
	output logic [asc_pkg::RES_W-1:0]         final_out
);
	typedef struct packed {
		logic [2:0]                s;
		logic                      lvl;
		logic [asc_pkg::RES_W-1:0] code;
		logic [asc_pkg::RES_W-1:0] mask;
	} asc_sar_t;
	asc_sar_t r, n;

	// High comparator means input is at or above the trial level
	assign final_out = r.lvl ? r.code : (r.code & ~r.mask);
	assign dac_out   = r.code;

	always_comb
	begin
		n   = r;
		n.s = {r.s[1:0], cmp_in};
		if (r.s[1] == r.s[2])
			n.lvl = r.s[2];
		if (decide_in)
		begin
			n.mask = r.mask >> 1;
			n.code = final_out | n.mask;
		end
		if (load_in)
		begin
			n.code = asc_pkg::SAR_FIRST;
			n.mask = asc_pkg::SAR_FIRST;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			r <= '0;
		else
			r <= n;
	end
endmodule: asc_sar

//--- asc_analog_model.sv
// Purpose: Far side of the sequencer: input multiplexer, ladder and comparator
// Assumes: Each channel carries a fixed level that never moves
// Notes: Level of a channel is its number above a fixed low offset
`timescale 1ns/1ps
module asc_analog_model (
	input  wire asc_pkg::asc_analog_t analog_in,
	output logic                      cmp_out
);
	logic [9:0] level;
	assign level = {analog_in.chan, 6'h2D};
	// High while the selected input is at or above the trial code
	assign cmp_out = (level >= analog_in.dac);
endmodule: asc_analog_model

//--- testbench.sv
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Comparator model holds one fixed level per channel
// Notes: Busy time is counted on the ladder output with always-on cleared
`timescale 1ns/1ps
module testbench;
	logic                 clk_sys;
	logic                 arst_n;
	logic                 standby;
	logic                 cmp;
	logic [7:0]           rdata;
	logic                 irq;
	asc_pkg::asc_bus_t    bus;
	asc_pkg::asc_analog_t ana;
	int                   failures;
	int                   check_count;
	logic [7:0]           rv;
	int                   n;

	asc_sequencer dut_u (.clk_sys_in(clk_sys), .arst_n_in(arst_n), .bus_in(bus),
		.standby_in(standby), .cmp_in(cmp), .rdata_out(rdata), .analog_out(ana),
		.conversion_done_irq_out(irq));
	asc_analog_model model_u (.analog_in(ana), .cmp_out(cmp));

	function automatic logic [9:0] lvl(input logic [3:0] c);
		lvl = {c, 6'h2D};
	endfunction: lvl

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask: chk

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask: wr

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask: rd

	// Counts ladder cycles and cycles until the completion pulse
	task automatic run(output int busy, output int k);
		busy = 0;
		k = 0;
		while (irq !== 1'b1 && k < 3000)
		begin
			@(posedge clk_sys);
			#1;
			if (ana.ladder_on === 1'b1)
				busy++;
			k++;
		end
		chk(16'(k < 3000), 16'h1);
		@(posedge clk_sys);
		#1 chk(16'(irq), 16'h0);
	endtask: run

	// Counts cycles with a pulse or the ladder up
	task automatic quiet(input int cyc);
		n = 0;
		repeat (cyc)
		begin
			@(posedge clk_sys);
			#1;
			if (irq !== 1'b0 || ana.ladder_on !== 1'b0)
				n++;
		end
	endtask: quiet

	task automatic t_reset();
		for (int i = 0; i < 4; i++)
		begin
			rd(2'(i), rv);
			chk(16'(rv), 16'h0);
		end
		// Reserved mode with start set: nothing may start
		wr(2'h0, 8'hD0);
		#1 chk(16'(ana.input_off), 16'h1);
		rd(2'h3, rv);
		chk(16'(rv), 16'h0);
		wr(2'h0, 8'h00);
		$display("Test reset done");
	endtask: t_reset

	task automatic t_times();
		int b;
		int k;
		int s;
		for (int i = 0; i < 8; i++)
		begin
			s = (i == 0) ? 0 : (i == 1 || i == 7) ? 5 : i - 1;
			wr(2'h1, {4'h1, 3'(i), 1'b0});
			wr(2'h0, 8'hA3);
			run(b, k);
			chk(16'(b), 16'(39 << s));
		end
		$display("Test times done");
	endtask: t_times

	task automatic t_single();
		int b;
		int k;
		logic [9:0] e;
		e = lvl(4'h3);
		wr(2'h1, 8'h16);
		wr(2'h0, 8'hA3);
		rd(2'h0, rv);
		chk(16'(rv), 16'h23);
		chk(16'(ana.chan), 16'h3);
		chk(16'(ana.sample), 16'h1);
		run(b, k);
		rd(2'h3, rv);
		chk(16'(rv), 16'({e[1:0], 6'h20}));
		rd(2'h2, rv);
		chk(16'(rv), 16'(e[9:2]));
		rd(2'h3, rv);
		chk(16'(rv), 16'({e[1:0], 6'h00}));
		rd(2'h1, rv);
		chk(16'(rv), 16'h16);
		$display("Test single done");
	endtask: t_single

	task automatic t_repeat();
		int b;
		int k;
		logic [9:0] e;
		e = lvl(4'h5);
		wr(2'h1, 8'h14);
		wr(2'h0, 8'hE5);
		run(b, k);
		run(b, k);
		chk(16'(k + 1), 16'(78));
		rd(2'h3, rv);
		chk(16'(rv), 16'({e[1:0], 6'h30}));
		repeat (25) @(posedge clk_sys);
		wr(2'h0, 8'h05);
		quiet(200);
		chk(16'(n), 16'h0);
		rd(2'h2, rv);
		chk(16'(rv), 16'(e[9:2]));
		$display("Test repeat done");
	endtask: t_repeat

	task automatic t_standby();
		wr(2'h1, 8'h24);
		wr(2'h0, 8'hA3);
		repeat (10) @(posedge clk_sys);
		rd(2'h3, rv);
		chk(16'(rv[4]), 16'h1);
		chk(16'(ana.ladder_on), 16'h1);
		@(posedge clk_sys);
		standby <= 1'b1;
		quiet(20);
		chk(16'(n), 16'h0);
		@(posedge clk_sys);
		standby <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd(2'(i), rv);
			chk(16'(rv), 16'h0);
		end
		quiet(200);
		chk(16'(n), 16'h0);
		$display("Test standby done");
	endtask: t_standby

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask: summarize

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// About 6000 cycles of tests; this cuts a hang short
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		failures++;
		summarize();
	end

	initial
	begin
		failures = 0;
		check_count = 0;
		arst_n = 1'b0;
		standby = 1'b0;
		bus = '0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_times();
		t_single();
		t_repeat();
		t_standby();
		summarize();
	end
endmodule: testbench
